// File: pdt_top.sv
// Operation
// - measure output versus reference phase each second
// - steer tuning offset, no software clamp
// - mode bit 4 enables disciplining
// - enable and time constant kept non-volatile
// - reset variables, then sync pulse
// - initialize on enable or on lock
// - reference lost: hold, resume without reinit
// - drift over 1 us: resync only
// - disable then enable forces reinitialization
// - report latest phase in whole ns
// - phase is external minus internal
// - state 0 start, 1 settled, 2 holdover
// - autosync and discipline clear each other
// - signed cable compensation, 100 ps, 100 ns
// - compensation applies to previous measurement (a write recomputes the correction from the stored phase, except in a reference-edge cycle)
// - compensation only in steering, raw reported
// - 32-bit seconds count on output edge
// - query answers N+1 at next edge
// - seconds load absolute or add difference
// - analog tuning updated once per second
// - sync aligns divider to reference edge
// - mode bit 3 syncs every reference edge
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "pdt_params.svh"
module pdt_top #(
	parameter int unsigned SEC_CYC = `PDT_SEC_CYC,
	parameter int unsigned MISS_CYC = `PDT_MISS_CYC,
	parameter int unsigned ADC_W = 12
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire pdt_pkg::pdt_bus_type i_bus,
	output logic [31:0] o_rdata,
	input wire logic i_reference_pulse_in,
	input wire pdt_pkg::pdt_lock_type i_lock,
	input wire logic [ADC_W-1:0] i_tune_adc,
	input wire logic i_nv_disc_en,
	input wire logic [13:0] i_nv_tconst,
	output logic o_output_pulse,
	output logic [31:0] o_tune_offset,
	output logic o_tune_update,
	output logic o_tod_valid,
	output logic [31:0] o_tod_value,
	output logic [1:0] o_discipline_state,
	output logic o_nv_wr,
	output logic o_nv_disc_en,
	output logic [13:0] o_nv_tconst
);
	import pdt_pkg::*;

	// ----------------------------------------
	// register bus decode
	// ----------------------------------------
	logic wr_mode, wr_tc, wr_cab, wr_sec, wr_add, wr_qry, wr_cmd, wr_thr;
	assign wr_mode = i_bus.wr && i_bus.addr == `PDT_MODE_OFS;
	assign wr_tc = i_bus.wr && i_bus.addr == `PDT_TCONST_OFS;
	assign wr_cab = i_bus.wr && i_bus.addr == `PDT_CABLE_OFS;
	assign wr_sec = i_bus.wr && i_bus.addr == `PDT_SEC_OFS;
	assign wr_add = i_bus.wr && i_bus.addr == `PDT_SEC_ADD_OFS;
	assign wr_qry = i_bus.wr && i_bus.addr == `PDT_TOD_QRY_OFS;
	assign wr_cmd = i_bus.wr && i_bus.addr == `PDT_CMD_OFS;
	assign wr_thr = i_bus.wr && i_bus.addr == `PDT_THRESH_OFS;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] ref_sq;
	pdt_lock_type lk_a_q, lk_b_q;
	logic lock_prev_q;
	logic ref_edge, locked, lock_rise;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ref_sq <= 3'h0;
			lk_a_q <= '{alarm: 1'b1, status: 4'hF};
			lk_b_q <= '{alarm: 1'b1, status: 4'hF};
			lock_prev_q <= 1'b0;
		end else begin
			ref_sq <= {ref_sq[1:0], i_reference_pulse_in};
			lk_a_q <= i_lock;
			lk_b_q <= lk_a_q;
			lock_prev_q <= locked;
		end
	end
	assign ref_edge = ref_sq[1] & ~ref_sq[2];
	assign locked = ~lk_b_q.alarm && lk_b_q.status == 4'h0;
	assign lock_rise = locked & ~lock_prev_q;

	// ----------------------------------------
	// mode, time constant, compensation
	// ----------------------------------------
	logic [15:0] mode_q, thr_q;
	logic [13:0] tc_q;
	logic signed [15:0] comp_q;
	logic nv_ld_q, sync_arm_q;
	logic disc_en, async_en, sync_now;
	logic signed [31:0] wsig;
	assign wsig = $signed(i_bus.wdata);
	assign disc_en = mode_q[`PDT_DISC_BIT];
	assign async_en = mode_q[`PDT_ASYNC_BIT];
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			mode_q <= `PDT_MODE_RST;
			tc_q <= `PDT_TCONST_RST;
			nv_ld_q <= 1'b0;
			o_nv_wr <= 1'b0;
		end else begin
			nv_ld_q <= 1'b1;
			o_nv_wr <= 1'b0;
			// settings restored one cycle after reset release
			if (!nv_ld_q) begin
				mode_q[`PDT_DISC_BIT] <= i_nv_disc_en;
				if (i_nv_tconst >= `PDT_TC_MIN && i_nv_tconst <= `PDT_TC_MAX) begin
					tc_q <= i_nv_tconst;
				end
			end else if (wr_mode) begin
				mode_q <= i_bus.wdata[15:0];
				o_nv_wr <= 1'b1;
				if (i_bus.wdata[`PDT_DISC_BIT] && !disc_en) begin
					mode_q[`PDT_ASYNC_BIT] <= 1'b0;
				end else if (i_bus.wdata[`PDT_ASYNC_BIT] && !async_en) begin
					mode_q[`PDT_DISC_BIT] <= 1'b0;
				end
			end else if (wr_tc) begin
				// out-of-range value is dropped, old one kept
				if (i_bus.wdata[31:0] >= 32'(`PDT_TC_MIN)
						&& i_bus.wdata[31:0] <= 32'(`PDT_TC_MAX)) begin
					tc_q <= i_bus.wdata[13:0];
					o_nv_wr <= 1'b1;
				end
			end
		end
	end
	assign o_nv_disc_en = mode_q[`PDT_DISC_BIT];
	assign o_nv_tconst = tc_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			comp_q <= 16'sh0000;
			thr_q <= `PDT_THRESH_RST;
		end else begin
			if (wr_cab) begin
				if (wsig > `PDT_COMP_MAX) begin
					comp_q <= 16'(`PDT_COMP_MAX);
				end else if (wsig < -`PDT_COMP_MAX) begin
					comp_q <= 16'(-`PDT_COMP_MAX);
				end else begin
					comp_q <= wsig[15:0];
				end
			end
			if (wr_thr) begin
				thr_q <= i_bus.wdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// output pulse divider
	// ----------------------------------------
	pdt_dsc_type ds_q;
	logic [31:0] cnt_q, cnt_d;
	logic tick, hold_resync;
	logic signed [31:0] pc_w, pn_w;
	assign sync_now = ref_edge
		& (async_en | sync_arm_q | ds_q == DS_INIT | hold_resync);
	always_comb begin
		if (sync_now) begin
			// detection lag folded in so the edge lands on the reference
			cnt_d = 32'(`PDT_SYNC_LAT);
		end else if (cnt_q == 32'(SEC_CYC - 1)) begin
			cnt_d = 32'h0000_0000;
		end else begin
			cnt_d = cnt_q + 32'h0000_0001;
		end
	end
	assign tick = cnt_d < 32'(`PDT_PULSE_CYC) && !o_output_pulse;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cnt_q <= 32'h0000_0000;
			o_output_pulse <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_output_pulse <= cnt_d < 32'(`PDT_PULSE_CYC);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			sync_arm_q <= 1'b0;
		end else if (wr_cmd && i_bus.wdata[`PDT_SYNC_CMD_BIT]) begin
			sync_arm_q <= 1'b1;
		end else if (ref_edge) begin
			sync_arm_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// phase meter
	// ----------------------------------------
	// resolution is one clock period, coarser than the analog meter
	always_comb begin
		pc_w = $signed(cnt_q) - 32'sd2;
		if (pc_w >= $signed(32'(SEC_CYC / 2))) begin
			pc_w = pc_w - $signed(32'(SEC_CYC));
		end
		pn_w = 32'(pc_w * `PDT_CLK_NS);
	end
	assign hold_resync = ds_q == DS_HOLD
		&& (pn_w > `PDT_RESYNC_NS || pn_w < -`PDT_RESYNC_NS);

	logic signed [31:0] ph_q, corr_q;
	logic meas_q;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ph_q <= 32'sh0000_0000;
			corr_q <= 32'sh0000_0000;
			meas_q <= 1'b0;
		end else begin
			// a measurement taken across a sync is not steered on
			meas_q <= ref_edge & ~sync_now;
			if (ref_edge) begin
				ph_q <= pn_w;
				corr_q <= 32'(pn_w * 10) + 32'(comp_q);
			end else if (wr_cab) begin
				corr_q <= 32'(ph_q * 10) + 32'(comp_q);
			end
		end
	end

	// ----------------------------------------
	// reference watchdog
	// ----------------------------------------
	logic [31:0] miss_q;
	logic miss;
	assign miss = miss_q == 32'(MISS_CYC);
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || ref_edge) begin
			miss_q <= 32'h0000_0000;
		end else if (!miss) begin
			miss_q <= miss_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// discipline control
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !disc_en) begin
			ds_q <= DS_OFF;
		end else if (lock_rise) begin
			ds_q <= DS_INIT;
		end else begin
			unique case (ds_q)
				DS_OFF: begin
					ds_q <= DS_INIT;
				end
				DS_INIT: begin
					if (ref_edge) begin
						ds_q <= DS_RUN;
					end
				end
				DS_RUN: begin
					if (miss) begin
						ds_q <= DS_HOLD;
					end
				end
				DS_HOLD: begin
					if (ref_edge) begin
						ds_q <= DS_RUN;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// steering
	// ----------------------------------------
	logic signed [31:0] integ_q, steer_q, p_w, tcs;
	assign tcs = $signed({18'h0_0000, tc_q});
	assign p_w = -corr_q / tcs;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || ds_q == DS_INIT) begin
			integ_q <= 32'sh0000_0000;
			steer_q <= 32'sh0000_0000;
		end else if (meas_q && ds_q == DS_RUN) begin
			// unbounded on purpose, only the word width limits it
			integ_q <= integ_q + p_w / tcs;
			steer_q <= integ_q + p_w;
		end
	end

	// ----------------------------------------
	// settled indicator
	// ----------------------------------------
	logic [15:0] ok_q;
	logic settled;
	assign settled = 17'(ok_q) >= 17'({tc_q, 1'b0});
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || ds_q != DS_RUN) begin
			ok_q <= 16'h0000;
		end else if (meas_q) begin
			if (ph_q < $signed({16'h0000, thr_q})
					&& ph_q > -$signed({16'h0000, thr_q})) begin
				if (!settled) begin
					ok_q <= ok_q + 16'h0001;
				end
			end else begin
				ok_q <= 16'h0000;
			end
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_discipline_state <= 2'h0;
		end else if (ds_q == DS_HOLD) begin
			o_discipline_state <= 2'h2;
		end else if (settled && ds_q == DS_RUN) begin
			o_discipline_state <= 2'h1;
		end else begin
			o_discipline_state <= 2'h0;
		end
	end

	// ----------------------------------------
	// tuning output
	// ----------------------------------------
	// sample taken at the edge itself, so the analog term never lags a second
	logic signed [31:0] atune_w;
	always_comb begin
		if (mode_q[`PDT_ATUNE_BIT]) begin
			atune_w = 32'($signed({1'b0, i_tune_adc})
				- $signed({1'b0, `PDT_ADC_MID}));
		end else begin
			atune_w = 32'sh0000_0000;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_tune_offset <= 32'h0000_0000;
			o_tune_update <= 1'b0;
		end else begin
			o_tune_update <= tick;
			if (tick) begin
				o_tune_offset <= steer_q + atune_w;
			end
		end
	end

	// ----------------------------------------
	// seconds counter
	// ----------------------------------------
	logic [31:0] sec_q, sec_d, sec_base;
	logic qry_q;
	always_comb begin
		if (wr_sec) begin
			sec_base = i_bus.wdata;
		end else if (wr_add) begin
			sec_base = sec_q + i_bus.wdata;
		end else begin
			sec_base = sec_q;
		end
		sec_d = sec_base + {31'h0000_0000, tick};
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			sec_q <= 32'h0000_0000;
			qry_q <= 1'b0;
			o_tod_valid <= 1'b0;
			o_tod_value <= 32'h0000_0000;
		end else begin
			sec_q <= sec_d;
			o_tod_valid <= tick & qry_q;
			if (tick & qry_q) begin
				o_tod_value <= sec_d;
			end
			if (wr_qry) begin
				qry_q <= 1'b1;
			end else if (tick) begin
				qry_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !i_bus.rd) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			unique case (i_bus.addr)
				`PDT_MODE_OFS: o_rdata <= {16'h0000, mode_q};
				`PDT_TCONST_OFS: o_rdata <= {18'h0_0000, tc_q};
				`PDT_CABLE_OFS: o_rdata <= 32'(comp_q);
				`PDT_STATUS_OFS: o_rdata <= {26'h000_0000, sync_arm_q, locked,
					~miss, ds_q == DS_HOLD, o_discipline_state};
				`PDT_PHASE_OFS: o_rdata <= disc_en ? ph_q : 32'h0000_0000;
				`PDT_STEER_OFS: o_rdata <= o_tune_offset;
				`PDT_SEC_OFS: o_rdata <= sec_q;
				`PDT_THRESH_OFS: o_rdata <= {16'h0000, thr_q};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// File: pdt_params.svh
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PDT_CLK_NS 8
`define PDT_SEC_NS 1000000000
`define PDT_SEC_CYC (`PDT_SEC_NS / `PDT_CLK_NS)
`define PDT_MISS_NS 1100000000
`define PDT_MISS_CYC (`PDT_MISS_NS / `PDT_CLK_NS)
`define PDT_PULSE_NS 20000
`define PDT_PULSE_CYC ((`PDT_PULSE_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_RESYNC_NS 1000
`define PDT_SYNC_LAT 3
`define PDT_PH_RES_PS 450
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDT_MODE_OFS 8'h00
`define PDT_TCONST_OFS 8'h04
`define PDT_CABLE_OFS 8'h08
`define PDT_STATUS_OFS 8'h0C
`define PDT_PHASE_OFS 8'h10
`define PDT_STEER_OFS 8'h14
`define PDT_SEC_OFS 8'h18
`define PDT_SEC_ADD_OFS 8'h1C
`define PDT_TOD_QRY_OFS 8'h20
`define PDT_THRESH_OFS 8'h24
`define PDT_CMD_OFS 8'h28
// ----------------------------------------
// fields, resets and limits
// ----------------------------------------
`define PDT_ATUNE_BIT 1
`define PDT_ASYNC_BIT 3
`define PDT_DISC_BIT 4
`define PDT_SYNC_CMD_BIT 0
`define PDT_MODE_RST 16'h0000
`define PDT_TCONST_RST 14'h0064
`define PDT_THRESH_RST 16'h0064
`define PDT_TC_MIN 14'h000A
`define PDT_TC_MAX 14'h2710
`define PDT_COMP_LSB_PS 100
`define PDT_COMP_LIM_PS 100000
`define PDT_COMP_MAX (`PDT_COMP_LIM_PS / `PDT_COMP_LSB_PS)
`define PDT_ADC_MID 12'h0800
`endif

// File: pdt_pkg.sv
package pdt_pkg;
	typedef enum {DS_OFF, DS_INIT, DS_RUN, DS_HOLD} pdt_dsc_type;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pdt_bus_type;
	typedef struct packed {
		logic alarm;
		logic [3:0] status;
	} pdt_lock_type;
endpackage

// File: pdt_ref_src.sv
`timescale 1ns/1ps
module pdt_ref_src #(
	parameter int unsigned SEC_CYC = 3000,
	parameter int unsigned HIGH_CYC = 100
) (
	input wire logic i_sys_clk,
	input wire logic i_run,
	input wire logic [31:0] i_delay,
	output logic o_reference_pulse_in = 1'b0
);
	// ----
	// reference source
	// ----
	logic [31:0] cnt_q = 32'h0000;
	logic [31:0] dly_q = 32'h0000;
	logic run_q = 1'b0;
	always_ff @(posedge i_sys_clk) begin
		cnt_q <= (cnt_q == SEC_CYC - 1) ? 32'h0000 : cnt_q + 32'h0001;
	end
	// settings taken at wrap only, so a change never splits or adds an edge
	always_ff @(posedge i_sys_clk) begin
		if (cnt_q == SEC_CYC - 1) begin
			dly_q <= i_delay;
			run_q <= i_run;
		end
	end
	// line sits low while the source is absent
	always_ff @(posedge i_sys_clk) begin
		o_reference_pulse_in <= run_q && cnt_q >= dly_q && cnt_q < dly_q + HIGH_CYC;
	end
endmodule

// File: pdt_top_sva.sv
`timescale 1ns/1ps
`include "pdt_params.svh"
module pdt_top_sva (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire pdt_pkg::pdt_bus_type i_bus,
	input wire logic [31:0] o_rdata,
	input wire logic o_output_pulse,
	input wire logic o_tune_update,
	input wire logic o_tod_valid,
	input wire logic [1:0] o_discipline_state,
	input wire logic o_nv_wr,
	input wire logic o_nv_disc_en,
	input wire logic [13:0] o_nv_tconst
);
	import pdt_pkg::*;
	logic md_wr, tc_wr, tc_ok, disc_bit;
	logic [13:0] wd_tc;
	assign md_wr = i_bus.wr && i_bus.addr == `PDT_MODE_OFS;
	assign tc_wr = i_bus.wr && i_bus.addr == `PDT_TCONST_OFS;
	assign tc_ok = i_bus.wdata >= `PDT_TC_MIN && i_bus.wdata <= `PDT_TC_MAX;
	assign disc_bit = i_bus.wdata[`PDT_DISC_BIT];
	assign wd_tc = i_bus.wdata[13:0];
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// ----
	// assertions
	// ----
	a_upd_on_rise: assert property (o_tune_update |-> $rose(o_output_pulse))
		else $error("tune update without output edge");
	a_rise_has_upd: assert property ($rose(o_output_pulse) |-> o_tune_update)
		else $error("output edge without tune update");
	a_pulse_holds: assert property ($rose(o_output_pulse) |-> o_output_pulse[*4])
		else $error("output pulse too short");
	a_tod_on_edge: assert property (o_tod_valid |-> $rose(o_output_pulse))
		else $error("seconds answer off the output edge");
	a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000)
		else $error("read data outside its cycle");
	a_state_legal: assert property (o_discipline_state != 2'h3)
		else $error("illegal discipline state");
	a_mode_stored: assert property (md_wr |=> o_nv_wr && o_nv_disc_en == $past(disc_bit))
		else $error("mode write not stored");
	a_tc_taken: assert property (tc_wr && tc_ok |=> o_nv_wr && o_nv_tconst == $past(wd_tc))
		else $error("time constant not stored");
	a_tc_refused: assert property (tc_wr && !tc_ok |=> !o_nv_wr && $stable(o_nv_tconst))
		else $error("bad time constant applied");
	c_tod: cover property (o_tod_valid);
	c_hold: cover property (o_discipline_state == 2'h2);
	c_tc_bad: cover property (tc_wr && !tc_ok);
endmodule
bind pdt_top pdt_top_sva u_sva (.i_sys_clk, .i_reset, .i_bus, .o_rdata, .o_output_pulse,
	.o_tune_update, .o_tod_valid, .o_discipline_state, .o_nv_wr, .o_nv_disc_en, .o_nv_tconst);

// File: tb.sv
`timescale 1ns/1ps
`include "pdt_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
	import pdt_pkg::*;
	localparam int unsigned SEC = 3000;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	pdt_bus_type i_bus = '0;
	pdt_lock_type i_lock = 5'h18;
	logic [11:0] i_tune_adc = `PDT_ADC_MID;
	logic run = 1'b0;
	logic [31:0] dly = 32'h0000;
	logic i_reference_pulse_in, o_output_pulse, o_tune_update, o_tod_valid, o_nv_wr, o_nv_disc_en;
	logic [31:0] o_rdata, o_tune_offset, o_tod_value, v, tc, held;
	logic [1:0] o_discipline_state;
	logic [13:0] o_nv_tconst;
	logic [31:0] tcs[4] = '{32'h0009, 32'h000A, 32'h2710, 32'h2711};
	logic [31:0] mw[4] = '{32'h0008, 32'h0018, 32'h0010, 32'h0008};
	logic [31:0] mr[4] = '{32'h0008, 32'h0010, 32'h0010, 32'h0008};
	int cab[4] = '{2000, -450, -1001, 1000};
	int c;
	int failures = 0;
	int n_checks = 0;
	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	pdt_top #(.SEC_CYC(SEC), .MISS_CYC(3300)) uut (.i_sys_clk, .i_reset, .i_bus, .o_rdata,
		.i_reference_pulse_in, .i_lock, .i_tune_adc, .i_nv_disc_en(1'b0), .i_nv_tconst(14'h00C8),
		.o_output_pulse, .o_tune_offset, .o_tune_update, .o_tod_valid, .o_tod_value,
		.o_discipline_state, .o_nv_wr, .o_nv_disc_en, .o_nv_tconst);
	pdt_ref_src #(.SEC_CYC(SEC)) src (.i_sys_clk, .i_run(run), .i_delay(dly),
		.o_reference_pulse_in(i_reference_pulse_in));
	// ----
	// bus, waits, expectations
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_sys_clk);
		i_bus <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge i_sys_clk);
		i_bus.wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge i_sys_clk);
		i_bus <= '{addr: a, wdata: 32'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_sys_clk);
		i_bus.rd <= 1'b0;
		#1 `CHK(nm, e, o_rdata)
	endtask
	// bounded so a dead output cannot hang the run
	task automatic wait_ev(input bit seconds_counter);
		int k = 0;
		do begin
			@(posedge i_sys_clk);
			#1 k++;
		end while ((seconds_counter ? o_tod_valid : o_tune_update) !== 1'b1 && k < SEC + 500);
		if (k >= SEC + 500) failures++;
	endtask
	task automatic secs(input int n);
		repeat (n * SEC) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask
	function automatic logic [31:0] f_tc(input logic [31:0] old, input logic [31:0] x);
		return (x >= `PDT_TC_MIN && x <= `PDT_TC_MAX) ? x : old;
	endfunction
	function automatic logic [31:0] f_cab(input int x);
		return 32'(x > `PDT_COMP_MAX ? `PDT_COMP_MAX : x < -`PDT_COMP_MAX ? -`PDT_COMP_MAX : x);
	endfunction
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge i_sys_clk);
		failures++;
		complete_run();
	end
	// ----
	// scenarios
	// ----
	initial begin
		v = $urandom(32'h05f85d9f);
		repeat (6) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		run <= 1'b1;
		i_lock <= 5'h00;
		repeat (2) @(posedge i_sys_clk);
		#1 `CHK("state", 2'h0, o_discipline_state)
		rdchk(`PDT_MODE_OFS, 32'h0000, "mode");
		rdchk(`PDT_TCONST_OFS, 32'h00C8, "tconst");
		rdchk(`PDT_THRESH_OFS, 32'h0064, "thresh");
		rdchk(8'h30, 32'h0000, "unmapped");
		rdchk(`PDT_TOD_QRY_OFS, 32'h0000, "write only");
		tdone("reset");
		tc = 32'h00C8;
		for (int i = 0; i < 5; i++) begin
			v = (i == 4) ? 32'h000A + $urandom_range(90) : tcs[i];
			wr(`PDT_TCONST_OFS, v);
			tc = f_tc(tc, v);
			rdchk(`PDT_TCONST_OFS, tc, "tconst");
			c = (i == 4) ? int'($urandom_range(4000)) - 2000 : cab[i];
			wr(`PDT_CABLE_OFS, c);
			rdchk(`PDT_CABLE_OFS, f_cab(c), "cable");
		end
		for (int i = 0; i < 4; i++) begin
			wr(`PDT_MODE_OFS, mw[i]);
			rdchk(`PDT_MODE_OFS, mr[i], "mode");
		end
		wr(`PDT_MODE_OFS, 32'h0000);
		tdone("registers");
		wait_ev(0);
		v = $urandom;
		wr(`PDT_SEC_OFS, v);
		rdchk(`PDT_SEC_OFS, v, "seconds");
		wr(`PDT_SEC_ADD_OFS, 32'hFFFF_FFFB);
		rdchk(`PDT_SEC_OFS, v - 32'h0005, "seconds");
		wr(`PDT_TOD_QRY_OFS, 32'h0001);
		wait_ev(1);
		`CHK("tod", v - 32'h0004, o_tod_value)
		rdchk(`PDT_SEC_OFS, v - 32'h0004, "seconds");
		tdone("seconds");
		wr(`PDT_MODE_OFS, 32'h0010);
		secs(3);
		rdchk(`PDT_PHASE_OFS, 32'h0000, "phase");
		dly <= 32'h0028;
		secs(2);
		rdchk(`PDT_PHASE_OFS, 32'h0140, "phase");
		`CHK("steering", 1'b1, o_tune_offset !== 32'h0000)
		i_lock <= 5'h18;
		dly <= 32'h0041;
		secs(1);
		i_lock <= 5'h00;
		secs(3);
		rdchk(`PDT_PHASE_OFS, 32'h0000, "phase");
		tdone("discipline");
		run <= 1'b0;
		secs(2);
		`CHK("state", 2'h2, o_discipline_state)
		held = o_tune_offset;
		secs(1);
		`CHK("held offset", held, o_tune_offset)
		dly <= 32'h0109;
		run <= 1'b1;
		secs(3);
		rdchk(`PDT_PHASE_OFS, 32'h0000, "phase");
		`CHK("resumed", 1'b1, o_discipline_state !== 2'h2)
		wr(`PDT_MODE_OFS, 32'h0000);
		rdchk(`PDT_PHASE_OFS, 32'h0000, "phase off");
		tdone("holdover");
		wr(`PDT_MODE_OFS, 32'h0002);
		wait_ev(0);
		repeat (3) @(posedge i_sys_clk);
		held = o_tune_offset;
		i_tune_adc <= 12'h0100 + 12'($urandom_range(1000));
		repeat (100) @(posedge i_sys_clk);
		`CHK("tune between", held, o_tune_offset)
		wait_ev(0);
		repeat (3) @(posedge i_sys_clk);
		`CHK("tune moved", 1'b1, o_tune_offset !== held)
		tdone("analog");
		complete_run();
	end
endmodule
